// ==== rtl/sss_consts.vh ====
// constants shared by the status summary and service request logic
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH

// status register part width and used bits (bit 15 always zero)
`define SSS_PART_W 16
`define SSS_USED_W 15

// status byte bit positions
`define SSS_STB_ERRQ 2
`define SSS_STB_QUES 3
`define SSS_STB_MSG  4
`define SSS_STB_ESB  5
`define SSS_STB_MSS  6
`define SSS_STB_OPER 7

// mask of status byte bits that may request service (not 0, 1, 6)
`define SSS_SRQ_USE 8'hbc

// reset values
`define SSS_SRE_RST 8'h00
`define SSS_ESE_RST 8'h00
`define SSS_PTR_RST 15'h7fff
`define SSS_NTR_RST 15'h0000
`define SSS_EN_RST  15'h0000

// command code: bit 3 selects a filtered register, bit 4 picks which
`define SSS_CMD_SCPI 3
`define SSS_CMD_QUES 4

// top-level commands, code[3] = 0, code[4] = 0
`define SSS_TOP_STB_Q 3'h0
`define SSS_TOP_POLL  3'h1
`define SSS_TOP_SRE_S 3'h2
`define SSS_TOP_SRE_Q 3'h3
`define SSS_TOP_ESE_S 3'h4
`define SSS_TOP_ESE_Q 3'h5
`define SSS_TOP_ESR_Q 3'h6

// filtered register functions, code[3] = 1
`define SSS_FN_COND_Q 3'h0
`define SSS_FN_EVT_Q  3'h1
`define SSS_FN_PTR_S  3'h2
`define SSS_FN_PTR_Q  3'h3
`define SSS_FN_NTR_S  3'h4
`define SSS_FN_NTR_Q  3'h5
`define SSS_FN_EN_S   3'h6
`define SSS_FN_EN_Q   3'h7

`endif

// ==== rtl/sss_scpi_reg.v ====
// one filtered status register: live state, edge filters, latch, mask
`timescale 1ns/10ps
`include "sss_consts.vh"

module sss_scpi_reg (
	// clock and reset
	input  wire                   clk_sys,
	input  wire                   rst,
	// live hardware state
	input  wire [`SSS_USED_W-1:0] condIn,
	// access from the command decoder
	input  wire                   fnStrobe,
	input  wire [2:0]             fnCode,
	input  wire [`SSS_USED_W-1:0] wrData,
	// results
	output reg  [`SSS_PART_W-1:0] rdWord,
	output wire                   sumBit
);

	reg  [`SSS_USED_W-1:0] condQ;
	reg  [`SSS_USED_W-1:0] ptrQ;
	reg  [`SSS_USED_W-1:0] ntrQ;
	reg  [`SSS_USED_W-1:0] enQ;
	reg  [`SSS_USED_W-1:0] evtQ;
	wire [`SSS_USED_W-1:0] evtSet;
	wire [`SSS_USED_W-1:0] evtClr;
	wire [`SSS_USED_W-1:0] evtD;

	// edge filters pick which transitions are latched
	assign evtSet = (condIn & ~condQ & ptrQ) | (~condIn & condQ & ntrQ); // R18
	// reading the latch clears it; a new edge in that cycle wins
	assign evtClr = (fnStrobe && fnCode == `SSS_FN_EVT_Q) ?
		{`SSS_USED_W{1'b1}} : {`SSS_USED_W{1'b0}}; // R19
	assign evtD = (evtQ & ~evtClr) | evtSet;
	// enabled latched bits or together, always live
	assign sumBit = |(evtQ & enQ); // R1 R4

	// state, latch and writable parts; reads leave all but the latch alone
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			condQ <= {`SSS_USED_W{1'b0}};
			ptrQ  <= `SSS_PTR_RST;
			ntrQ  <= `SSS_NTR_RST;
			enQ   <= `SSS_EN_RST;
			evtQ  <= {`SSS_USED_W{1'b0}};
		end else begin
			condQ <= condIn;
			evtQ  <= evtD;
			if (fnStrobe && fnCode == `SSS_FN_PTR_S) begin
				ptrQ <= wrData;
			end
			if (fnStrobe && fnCode == `SSS_FN_NTR_S) begin
				ntrQ <= wrData;
			end
			if (fnStrobe && fnCode == `SSS_FN_EN_S) begin
				enQ <= wrData; // R2
			end
		end
	end

	// read mux, bit 15 fixed at zero
	always @* begin
		case (fnCode)
			`SSS_FN_COND_Q: rdWord = {1'b0, condIn}; // R17 R19
			`SSS_FN_EVT_Q:  rdWord = {1'b0, evtQ};
			`SSS_FN_PTR_Q:  rdWord = {1'b0, ptrQ};
			`SSS_FN_NTR_Q:  rdWord = {1'b0, ntrQ};
			`SSS_FN_EN_Q:   rdWord = {1'b0, enQ}; // R2
			default:        rdWord = {`SSS_PART_W{1'b0}};
		endcase
	end

endmodule // sss_scpi_reg

// ==== rtl/sss_status_summary.v ====
// status byte, service request mask and summary hierarchy
//
// Behaviour
// R1: latched bits ANDed with mask, ORed to sum
// R2: masks writable and readable, reads keep contents
// R3: each sum feeds a bit one level up
// R4: sums are computed continuously
// R5: request mask and event mask act as enables
// R6: bit 6 is master summary, mask 6 ignored
// R7: request on enabled status bit rising
// R8: byte query and serial poll return status
// R9: request mask stored and returned on query
// R10: bit 2 error queue; entries request service
// R11: bit 3 is questionable register sum
// R12: bit 4 shows message waiting to read
// R13: bit 5 is standard event summary
// R14: bit 7 is operation register sum
// R15: controller should poll error queue afterwards
// R16: bits 0 and 1 carry no status
// R17: parts 16 bits, bit 15 zero
// R18: latch on filtered rising or falling edge
// R19: latch read clears; live part read only
// R20: bits 0,1 read zero, never request
// R21: request held while master summary is set
`timescale 1ns/10ps
`include "sss_consts.vh"

module sss_status_summary (
	// clock and reset
	input  wire                   clk_sys,
	input  wire                   rst,
	// command port from the remote interpreter
	input  wire                   cmdValid,
	input  wire [4:0]             cmdCode,
	input  wire [`SSS_PART_W-1:0] cmdData,
	// answer to queries
	output reg                    rspValid,
	output reg  [`SSS_PART_W-1:0] rspData,
	output reg                    rspBad,
	// live instrument state
	input  wire [`SSS_USED_W-1:0] opCond,
	input  wire [`SSS_USED_W-1:0] quesCond,
	input  wire [7:0]             stdEvent,
	// error queue and output buffer
	input  wire                   errEntry,
	input  wire                   errNotEmpty,
	input  wire                   msgWaiting,
	// summary outputs
	output reg  [7:0]             statusByte,
	output reg                    srqLevel,
	output reg                    srqPulse
);

	// mask of bits that may request service
	function [7:0] srq_bits;
		input [7:0] stb;
		input [7:0] mask;
		begin
			srq_bits = stb & mask & `SSS_SRQ_USE;
		end
	endfunction

	// decoded command
	wire       isScpi;
	wire       isQues;
	wire [2:0] fnCode;
	wire       opStrobe;
	wire       quesStrobe;
	wire       topStrobe;
	wire       badCmd;

	// top-level registers
	reg  [7:0] sreQ;
	reg  [7:0] eseQ;
	reg  [7:0] esrQ;
	wire [7:0] esrClr;
	wire [7:0] esrD;
	reg  [7:0] armedQ;
	reg        errSeenQ;

	// sums and status byte
	wire                   opSum;
	wire                   quesSum;
	wire                   esbSum;
	wire                   master_summary_bit;
	wire [7:0]             stbLive;
	wire [7:0]             armed;
	wire                   newReq;
	wire [`SSS_PART_W-1:0] opWord;
	wire [`SSS_PART_W-1:0] quesWord;
	reg  [`SSS_PART_W-1:0] topWord;
	reg                    topQuery;
	wire                   scpiQuery;

	// command decode
	assign isScpi = cmdCode[`SSS_CMD_SCPI];
	assign isQues = cmdCode[`SSS_CMD_QUES];
	assign fnCode = cmdCode[2:0];
	assign opStrobe = cmdValid & isScpi & ~isQues;
	assign quesStrobe = cmdValid & isScpi & isQues;
	assign topStrobe = cmdValid & ~isScpi & ~isQues;
	// top codes with bit 4 set, or the spare top code, are unknown
	assign badCmd = cmdValid & ~isScpi &
		(isQues | (fnCode == 3'h7));

	// operation register, lowest level
	sss_scpi_reg uOper (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.condIn   (opCond),
		.fnStrobe (opStrobe),
		.fnCode   (fnCode),
		.wrData   (cmdData[`SSS_USED_W-1:0]),
		.rdWord   (opWord),
		.sumBit   (opSum)
	);

	// questionable register, lowest level
	sss_scpi_reg uQues (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.condIn   (quesCond),
		.fnStrobe (quesStrobe),
		.fnCode   (fnCode),
		.wrData   (cmdData[`SSS_USED_W-1:0]),
		.rdWord   (quesWord),
		.sumBit   (quesSum)
	);

	// standard event latch: reading clears, a new event wins
	assign esrClr = (topStrobe && fnCode == `SSS_TOP_ESR_Q) ?
		8'hff : 8'h00; // R19
	assign esrD = (esrQ & ~esrClr) | stdEvent;

	// standard event summary via the event mask
	assign esbSum = |(esrQ & eseQ); // R1 R5 R13

	// status byte as the live state of the top level
	assign stbLive[0] = 1'b0; // R16 R20
	assign stbLive[1] = 1'b0; // R16 R20
	assign stbLive[`SSS_STB_ERRQ] = errNotEmpty | errSeenQ; // R10
	assign stbLive[`SSS_STB_QUES] = quesSum; // R3 R11
	assign stbLive[`SSS_STB_MSG] = msgWaiting; // R12
	assign stbLive[`SSS_STB_ESB] = esbSum; // R3 R13
	assign stbLive[`SSS_STB_MSS] = master_summary_bit; // R6
	assign stbLive[`SSS_STB_OPER] = opSum; // R3 R14

	// enabled bits; the request mask is the byte's enable part
	assign armed = srq_bits(stbLive, sreQ); // R5 R20
	// master summary ignores mask bit 6 via the use mask
	assign master_summary_bit = |armed; // R6
	// a fresh request on any enabled bit rising, or on a new error while request mask bit 2 is set
	assign newReq = (|(armed & ~armedQ)) |
		(errEntry & sreQ[`SSS_STB_ERRQ]); // R7 R10

	// show a new error entry in bit 2 for one cycle while the queue flag is still clear
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			errSeenQ <= 1'b0;
		end else begin
			errSeenQ <= errEntry & ~errNotEmpty; // R10
		end
	end

	// mask registers and the event latch
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sreQ <= `SSS_SRE_RST;
			eseQ <= `SSS_ESE_RST;
			esrQ <= 8'h00;
		end else begin
			esrQ <= esrD;
			if (topStrobe && fnCode == `SSS_TOP_SRE_S) begin
				sreQ <= cmdData[7:0]; // R9
			end
			if (topStrobe && fnCode == `SSS_TOP_ESE_S) begin
				eseQ <= cmdData[7:0]; // R2
			end
		end
	end

	// top-level read mux, reads change nothing but the latch
	always @* begin
		topQuery = 1'b1;
		case (fnCode)
			`SSS_TOP_STB_Q: topWord = {8'h00, stbLive}; // R8
			`SSS_TOP_POLL:  topWord = {8'h00, stbLive}; // R8
			`SSS_TOP_SRE_Q: topWord = {8'h00, sreQ}; // R9
			`SSS_TOP_ESE_Q: topWord = {8'h00, eseQ}; // R2
			`SSS_TOP_ESR_Q: topWord = {8'h00, esrQ};
			default: begin
				topWord = {`SSS_PART_W{1'b0}};
				topQuery = 1'b0;
			end
		endcase
	end

	// odd functions and function 0 of a filtered register are queries
	assign scpiQuery = fnCode[0] | (fnCode == `SSS_FN_COND_Q);

	// answer register, one cycle after the command
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rspValid <= 1'b0;
			rspData  <= {`SSS_PART_W{1'b0}};
			rspBad   <= 1'b0;
		end else begin
			rspValid <= 1'b0;
			rspBad   <= badCmd;
			if (opStrobe && scpiQuery) begin
				rspValid <= 1'b1;
				rspData  <= opWord; // R17
			end else if (quesStrobe && scpiQuery) begin
				rspValid <= 1'b1;
				rspData  <= quesWord; // R17
			end else if (topStrobe && topQuery) begin
				rspValid <= 1'b1;
				rspData  <= topWord;
			end
		end
	end

	// summary outputs and edge memory for requests
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			statusByte <= 8'h00;
			srqLevel   <= 1'b0;
			srqPulse   <= 1'b0;
			armedQ     <= 8'h00;
		end else begin
			statusByte <= stbLive;
			armedQ     <= armed;
			srqPulse   <= newReq; // R7 R10
			srqLevel   <= master_summary_bit; // R21
		end
	end

endmodule // sss_status_summary

// ==== sim/sss_host_model.sv ====
// remote controller model: sends commands, takes answers
`timescale 1ns/10ps
module sss_host_model (
	// clock
	input  wire        clk_sys,
	// command side
	output reg         cmdValid,
	output reg  [4:0]  cmdCode,
	output reg  [15:0] cmdData,
	// answer side
	input  wire        rspValid,
	input  wire [15:0] rspData,
	input  wire        rspBad
);
	// one command, answer read 1 ns after the edge that accepts it
	task xfer(input [4:0] c, input [15:0] d, output [15:0] w, output ok, output bad);
		begin
			@(posedge clk_sys);
			cmdValid <= 1'b1;
			cmdCode  <= c;
			cmdData  <= d;
			@(posedge clk_sys);
			cmdValid <= 1'b0;
			cmdData  <= ~d; // released data is not left showing
			#1;
			w   = rspData;
			ok  = rspValid;
			bad = rspBad;
		end
	endtask
	// idle at start
	initial begin
		cmdValid = 1'b0;
		cmdCode  = 5'h00;
		cmdData  = 16'h0000;
	end
endmodule // sss_host_model

// ==== sim/sss_status_summary_monitor.sv ====
// port assertions for the status summary block
`timescale 1ns/10ps
module sss_status_summary_monitor (
	// clock and reset
	input logic        clk_sys,
	input logic        rst,
	// commands and answers
	input logic        cmdValid,
	input logic [4:0]  cmdCode,
	input logic        rspValid,
	input logic [15:0] rspData,
	input logic        rspBad,
	// status
	input logic        errNotEmpty,
	input logic        msgWaiting,
	input logic [7:0]  statusByte,
	input logic        srqLevel,
	input logic        srqPulse
);
	// single clock domain
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	chk_unused_bits: assert property (statusByte[1:0] == 2'b00)
		else $error("status bits 0/1 set");
	chk_master_level: assert property (srqLevel == statusByte[6])
		else $error("request level differs from master bit");
	chk_msg_bit: assert property (statusByte[4] == $past(msgWaiting))
		else $error("message bit wrong");
	chk_err_bit: assert property (errNotEmpty |=> statusByte[2])
		else $error("error bit missing");
	chk_mask_query: assert property (cmdValid && cmdCode == 5'h03
		|=> rspValid && rspData[15:8] == 8'h00) else $error("mask query answer");
	chk_poll_value: assert property (cmdValid && cmdCode[4:1] == 4'h0
		|=> rspValid && rspData == {8'h00, statusByte}) else $error("poll answer");
	chk_refused_code: assert property (cmdValid && (cmdCode == 5'h07
		|| cmdCode[4:3] == 2'b10) |=> rspBad && !rspValid) else $error("bad code kept");
	chk_request_rise: assert property ($rose(srqLevel) |-> srqPulse)
		else $error("no request pulse");
endmodule // sss_status_summary_monitor

bind sss_status_summary sss_status_summary_monitor i_sss_status_summary_monitor (
	.clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
	.rspValid(rspValid), .rspData(rspData), .rspBad(rspBad),
	.errNotEmpty(errNotEmpty), .msgWaiting(msgWaiting),
	.statusByte(statusByte), .srqLevel(srqLevel), .srqPulse(srqPulse));

// ==== sim/test_sss_status_summary.sv ====
// self-checking bench for the status summary block
`timescale 1ns/10ps
module test_sss_status_summary;
	// design connections
	reg         clk_sys = 1'b0;
	reg         rst = 1'b1;
	reg  [14:0] opCond = 15'h0000;
	reg  [14:0] quesCond = 15'h0000;
	reg  [7:0]  stdEvent = 8'h00;
	reg         errEntry = 1'b0;
	reg         errNotEmpty = 1'b0;
	reg         msgWaiting = 1'b0;
	wire        cmdValid, rspValid, rspBad, srqLevel, srqPulse;
	wire [4:0]  cmdCode;
	wire [15:0] cmdData, rspData;
	wire [7:0]  statusByte;
	// bench state
	integer     errors = 0;
	integer     checked = 0;
	integer     pulses = 0;
	integer     i;
	reg  [15:0] w;
	reg         ok, bad;
	reg  [4:0]  b;

	sss_status_summary i_sss_status_summary (.clk_sys(clk_sys), .rst(rst),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData), .rspValid(rspValid),
		.rspData(rspData), .rspBad(rspBad), .opCond(opCond), .quesCond(quesCond),
		.stdEvent(stdEvent), .errEntry(errEntry), .errNotEmpty(errNotEmpty),
		.msgWaiting(msgWaiting), .statusByte(statusByte), .srqLevel(srqLevel),
		.srqPulse(srqPulse));
	sss_host_model i_sss_host_model (.clk_sys(clk_sys), .cmdValid(cmdValid),
		.cmdCode(cmdCode), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
		.rspBad(rspBad));

	// clock and request pulse counter
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (srqPulse === 1'b1) pulses <= pulses + 1;

	// comparisons
	task cmp(input string what, input [15:0] exp, input [15:0] got);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("[FAIL] %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task q(input [4:0] c, input [15:0] d);
		i_sss_host_model.xfer(c, d, w, ok, bad);
	endtask
	task settle;
		begin
			repeat (2) @(posedge clk_sys);
			#1;
		end
	endtask
	task conclude;
		begin
			$display("checked %0d errors %0d", checked, errors);
			if (errors == 0 && checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		q(5'h02, 16'h00bc);
		cmp("write answer", 16'h0000, {ok, bad});
		for (i = 0; i < 2; i = i + 1) begin
			q(5'h03, 16'h0000);
			cmp("request mask", 16'h00bc, w);
		end
		q(5'h04, 16'h0081);
		q(5'h05, 16'h0000);
		cmp("event mask", 16'h0081, w);
		$display("masks done");
		for (i = 0; i < 2; i = i + 1) begin
			b = i ? 5'h18 : 5'h08;
			q(b | 5'h06, 16'h0005);
			@(posedge clk_sys);
			if (i) quesCond <= 15'h0004;
			else opCond <= 15'h0001;
			settle;
			cmp("status byte", i ? 16'h0048 : 16'h00c0, statusByte);
			cmp("request level", 16'h0001, srqLevel);
			q(b, 16'h0000);
			cmp("live part", i ? 16'h0004 : 16'h0001, w);
			q(b | 5'h01, 16'h0000);
			cmp("latch part", i ? 16'h0004 : 16'h0001, w);
			q(b | 5'h01, 16'h0000);
			cmp("latch cleared", 16'h0000, w);
			cmp("status cleared", 16'h0000, {srqLevel, statusByte});
		end
		q(5'h0c, 16'h0001);
		@(posedge clk_sys);
		opCond <= 15'h0000;
		settle;
		cmp("falling edge", 16'h00c0, statusByte);
		q(5'h09, 16'h0000);
		$display("filtered registers done");
		@(posedge clk_sys);
		stdEvent <= 8'h82;
		@(posedge clk_sys);
		stdEvent <= 8'h00;
		@(posedge clk_sys);
		#1;
		cmp("event summary", 16'h0060, statusByte);
		q(5'h06, 16'h0000);
		cmp("event latch", 16'h0082, w);
		@(posedge clk_sys);
		msgWaiting <= 1'b1;
		settle;
		cmp("message bit", 16'h0050, statusByte);
		q(5'h01, 16'h0000);
		cmp("serial poll", 16'h0050, w);
		q(5'h00, 16'h0000);
		cmp("status query", 16'h0050, w);
		cmp("request pulses", 16'h0005, pulses[15:0]);
		$display("summary bits done");
		// inputs change only on a rising edge
		@(posedge clk_sys);
		msgWaiting <= 1'b0;
		errEntry <= 1'b1;
		errNotEmpty <= 1'b1;
		@(posedge clk_sys);
		errEntry <= 1'b0;
		settle;
		cmp("error bit", 16'h0044, statusByte);
		cmp("error request", 16'h0006, pulses[15:0]);
		// a second entry while bit 2 already stands must still request
		@(posedge clk_sys);
		errEntry <= 1'b1;
		@(posedge clk_sys);
		errEntry <= 1'b0;
		settle;
		cmp("repeat error", 16'h0007, pulses[15:0]);
		@(posedge clk_sys);
		errNotEmpty <= 1'b0; // controller drained the error queue
		q(5'h02, 16'h0043); // only bits 0, 1 and 6 enabled
		@(posedge clk_sys);
		msgWaiting <= 1'b1;
		settle;
		cmp("masked message", 16'h0010, {srqLevel, statusByte});
		for (i = 0; i < 9; i = i + 1) begin
			q(i ? 5'h0f + i[4:0] : 5'h07, 16'h00ff);
			cmp("refused code", 16'h0001, {ok, bad});
		end
		q(5'h03, 16'h0000);
		cmp("mask kept", 16'h0043, w);
		$display("errors and refusals done");
		conclude;
	end
endmodule // test_sss_status_summary
